// ### rtl/mts_twi_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "mts_defs.svh"
// What this block does
// - deselect aborts transfer, releases both lines
// - clock stretch bounded; host waits for release
// - non-volatile write completes within its window
// - volatile write completes; accesses refused meanwhile
// - new page mapped within page change time
// - read-only characteristics byte reports module traits
// - control bit gates hardware low-power input
// - control bit picks Tx squelch method
// - software bit holds module in low power
// - software reset bit resets the module
module mts_twi_slave #(
  parameter logic [6:0] DEV_ADDR = `MTS_DEV_ADDR,
  parameter logic MEM_FLAT = 1'b0,
  parameter logic STEPWISE = 1'b0,
  parameter logic [1:0] MAX_SPEED = 2'h0,
  parameter int unsigned NV_WR_CYC = `MTS_NV_WR_CYC,
  parameter int unsigned VOL_WR_CYC = `MTS_VOL_WR_CYC,
  parameter int unsigned BPC_CYC = `MTS_BPC_CYC,
  parameter int unsigned HOLD_CYC = `MTS_HOLD_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // two-wire link
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic module_select_n_i,
  // module side
  input wire logic hw_lowpower_input_i,
  output mts_pkg::mts_ctrl_t ctrl_o,
  output logic [7:0] page_o,
  output logic lowpower_o,
  output logic sw_module_reset_o,
  output logic busy_o
);
  import mts_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  logic scl_q;
  logic sda_q;
  logic sel_n_q;
  logic hwlp_q;
  logic scl_d;
  logic sda_d;
  logic sel_ok;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic bus_ev;
  mts_state_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic rw;
  logic ack_ok;
  logic sda_low;
  logic [7:0] ptr;
  logic [4:0] stretch_cnt;
  logic [31:0] busy_cnt;
  logic busy;
  logic wrote;
  logic nv_hit;
  logic page_hit;
  logic rst_hit;
  logic [7:0] page_pend;
  logic [7:0] page;
  mts_ctrl_t ctrl;
  logic lowpower;
  logic swrst;
  logic [7:0] char_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;
  logic byte_done;
  logic addr_hit;
  logic rx_shift;
  logic bit_count;
  logic wr_fire;
  logic commit_fire;
  logic ld_fire;
  logic [31:0] hold_cnt;

  // ----------------------------------------
  // reset release and input sampling
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  mts_sync3 #(.RST_VAL(1'b1)) u_sync_scl (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(scl_i),
    .q_o(scl_q)
  );
  mts_sync3 #(.RST_VAL(1'b1)) u_sync_sda (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(sda_i),
    .q_o(sda_q)
  );
  mts_sync3 #(.RST_VAL(1'b1)) u_sync_sel (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(module_select_n_i),
    .q_o(sel_n_q)
  );
  mts_sync3 #(.RST_VAL(1'b0)) u_sync_hwlp (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(hw_lowpower_input_i),
    .q_o(hwlp_q)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  // ----------------------------------------
  // bus event decode
  // ----------------------------------------
  assign sel_ok = ~sel_n_q;
  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign start_c = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_c = scl_q & scl_d & ~sda_d & sda_q;
  assign bus_ev = sel_ok & ~start_c & ~stop_c;
  assign byte_done = scl_fall & (cnt == `MTS_BITS_PER_BYTE);
  assign addr_hit = (shreg[7:1] == DEV_ADDR) & ~busy;
  assign rx_shift = ((state == ST_ADDR) | (state == ST_REG) |
                     (state == ST_WR)) & ~cnt[3];
  assign bit_count = rx_shift | ((state == ST_RD) & ~cnt[3]);
  assign wr_fire = bus_ev & (state == ST_WR) & byte_done;
  assign commit_fire = sel_ok & stop_c & wrote;
  assign ld_fire = bus_ev & scl_fall &
                   (((state == ST_ADDR_ACK) & rw) |
                    ((state == ST_RD_ACK) & ack_ok));

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always_comb begin
    char_byte = 8'h00;
    char_byte[`MTS_CHAR_MEM] = MEM_FLAT;
    char_byte[`MTS_CHAR_STEP] = STEPWISE;
    char_byte[`MTS_CHAR_SPD +: 2] = MAX_SPEED;
    ctrl_byte = 8'h00;
    ctrl_byte[`MTS_CTRL_HWEN] = ctrl.hw_lowpower_pin_enable;
    ctrl_byte[`MTS_CTRL_SQ] = ctrl.squelch_method_choice;
    ctrl_byte[`MTS_CTRL_SWLP] = ctrl.sw_lowpower_request;
  end

  assign rd_byte = (ptr == `MTS_OFS_CHAR) ? char_byte :
                   (ptr == `MTS_OFS_CTRL) ? ctrl_byte :
                   (ptr == `MTS_OFS_PAGE) ? page : 8'h00;

  // ----------------------------------------
  // serial slave sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      ack_ok <= 1'b0;
      sda_low <= 1'b0;
      ptr <= 8'h00;
    end else if (!sel_ok) begin
      state <= ST_IDLE;
      sda_low <= 1'b0;
    end else if (start_c) begin
      state <= ST_ADDR;
      cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (stop_c) begin
      state <= ST_IDLE;
      sda_low <= 1'b0;
    end else begin
      if (scl_rise && bit_count) begin
        cnt <= cnt + 4'h1;
      end
      if (scl_rise && rx_shift) begin
        shreg <= {shreg[6:0], sda_q};
      end
      case (state)
        ST_ADDR: begin
          if (byte_done) begin
            // busy commit refuses the address
            if (addr_hit) begin
              sda_low <= 1'b1;
              rw <= shreg[0];
              state <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          if (scl_rise) begin
            ack_ok <= ~sda_q;
          end
          if (scl_fall) begin
            cnt <= 4'h0;
            if (ld_fire) begin
              shreg <= {rd_byte[6:0], 1'b0};
              sda_low <= ~rd_byte[7];
              state <= ST_RD;
            end else if (state == ST_ADDR_ACK) begin
              sda_low <= 1'b0;
              state <= ST_REG;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt == `MTS_BITS_PER_BYTE) begin
              sda_low <= 1'b0;
              ptr <= ptr + 8'h01;
              state <= ST_RD_ACK;
            end else begin
              sda_low <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        ST_REG: begin
          if (byte_done) begin
            ptr <= shreg;
            sda_low <= 1'b1;
            state <= ST_REG_ACK;
          end
        end
        ST_WR: begin
          if (byte_done) begin
            ptr <= ptr + 8'h01;
            sda_low <= 1'b1;
            state <= ST_WR_ACK;
          end
        end
        ST_REG_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
            cnt <= 4'h0;
            state <= ST_WR;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // clock stretch while read data is fetched
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stretch_cnt <= 5'h00;
    end else if (!sel_ok) begin
      stretch_cnt <= 5'h00;
    end else if (ld_fire) begin
      stretch_cnt <= `MTS_STRETCH_CYC;
    end else if (stretch_cnt != 5'h00) begin
      stretch_cnt <= stretch_cnt - 5'h01;
    end
  end

  // ----------------------------------------
  // control registers and commit tracking
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `MTS_CTRL_RST;
      page <= `MTS_PAGE_RST;
      page_pend <= `MTS_PAGE_RST;
      swrst <= 1'b0;
    end else begin
      swrst <= commit_fire & rst_hit;
      if (commit_fire && rst_hit) begin
        ctrl <= `MTS_CTRL_RST;
        page <= `MTS_PAGE_RST;
      end else if (commit_fire && page_hit) begin
        page <= page_pend;
      end
      if (wr_fire && ptr == `MTS_OFS_CTRL) begin
        ctrl.hw_lowpower_pin_enable <= shreg[`MTS_CTRL_HWEN];
        ctrl.squelch_method_choice <= shreg[`MTS_CTRL_SQ];
        ctrl.sw_lowpower_request <= shreg[`MTS_CTRL_SWLP];
      end
      if (wr_fire && ptr == `MTS_OFS_PAGE) begin
        page_pend <= shreg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wrote <= 1'b0;
      nv_hit <= 1'b0;
      page_hit <= 1'b0;
      rst_hit <= 1'b0;
    end else if (commit_fire || !sel_ok) begin
      wrote <= 1'b0;
      nv_hit <= 1'b0;
      page_hit <= 1'b0;
      rst_hit <= 1'b0;
    end else if (wr_fire) begin
      wrote <= 1'b1;
      nv_hit <= nv_hit | (ptr >= `MTS_NV_BASE);
      page_hit <= page_hit | (ptr == `MTS_OFS_PAGE);
      rst_hit <= rst_hit | ((ptr == `MTS_OFS_CTRL) &
                            shreg[`MTS_CTRL_SWRST]);
    end
  end

  // ----------------------------------------
  // commit window and low-power level
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 32'h0;
    end else if (commit_fire) begin
      busy_cnt <= nv_hit ? NV_WR_CYC :
                  page_hit ? BPC_CYC : VOL_WR_CYC;
    end else if (busy) begin
      busy_cnt <= busy_cnt - 32'h1;
    end
  end
  assign busy = |busy_cnt;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lowpower <= 1'b0;
    end else begin
      lowpower <= ctrl.sw_lowpower_request |
                  (ctrl.hw_lowpower_pin_enable & hwlp_q);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = |stretch_cnt;
  assign sda_oe_o = sda_low;
  assign ctrl_o = ctrl;
  assign page_o = page;
  assign lowpower_o = lowpower;
  assign sw_module_reset_o = swrst;
  assign busy_o = busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 32'h0;
    end else if (scl_oe_o) begin
      hold_cnt <= hold_cnt + 32'h1;
    end else begin
      hold_cnt <= 32'h0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_deselect_release: assert property (!sel_ok |=>
    !sda_oe_o && !scl_oe_o)
    else $error("lines not released after deselect");
  a_unsel_silent: assert property ($rose(sda_oe_o) |-> $past(sel_ok))
    else $error("data line driven while deselected");
  a_stretch_bound: assert property (hold_cnt <= HOLD_CYC)
    else $error("clock held low beyond holdoff limit");
  a_stretch_start: assert property (ld_fire |=> scl_oe_o [*8])
    else $error("read fetch did not hold the clock");
  a_nv_window: assert property (commit_fire && nv_hit |=>
    busy_cnt == NV_WR_CYC)
    else $error("non-volatile window not loaded");
  a_vol_window: assert property (commit_fire && !nv_hit && !page_hit |=>
    busy_cnt == VOL_WR_CYC)
    else $error("volatile window not loaded");
  a_busy_refuse: assert property (state == ST_ADDR && byte_done &&
    busy && bus_ev |=> state == ST_IDLE && !sda_oe_o)
    else $error("address acknowledged while busy");
  a_page_map: assert property (commit_fire && page_hit && !rst_hit |=>
    page_o == $past(page_pend))
    else $error("page not mapped at commit");
  a_char_read: assert property (ld_fire && ptr == `MTS_OFS_CHAR |=>
    sda_oe_o == ~char_byte[7] && shreg[7:1] == char_byte[6:0])
    else $error("characteristics byte not presented");
  a_hw_gate: assert property (!ctrl.hw_lowpower_pin_enable &&
    !ctrl.sw_lowpower_request |=> !lowpower_o)
    else $error("hardware low-power input not ignored");
  a_squelch_sel: assert property (wr_fire && ptr == `MTS_OFS_CTRL |=>
    ctrl_o.squelch_method_choice == $past(shreg[`MTS_CTRL_SQ]))
    else $error("squelch method not taken");
  a_sw_lowpower: assert property (ctrl.sw_lowpower_request ##1
    ctrl.sw_lowpower_request |-> lowpower_o)
    else $error("software low-power not held");
  a_sw_reset: assert property (commit_fire && rst_hit |=>
    sw_module_reset_o && ctrl_o == `MTS_CTRL_RST ##1 !sw_module_reset_o)
    else $error("software reset not issued");

  c_read: cover property (ld_fire && state == ST_RD_ACK);
  c_commit: cover property (commit_fire);
  c_abort: cover property ($fell(sel_ok) && state != ST_IDLE);
  c_page: cover property (commit_fire && page_hit);

endmodule

`default_nettype wire

// ### include/mts_defs.svh
`ifndef MTS_DEFS_SVH
`define MTS_DEFS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MTS_CLK_KHZ 125000
`define MTS_NV_WR_MS 80
`define MTS_VOL_WR_MS 10
`define MTS_BPC_MS 10
`define MTS_HOLD_US 500
`define MTS_NV_WR_CYC (`MTS_NV_WR_MS * `MTS_CLK_KHZ)
`define MTS_VOL_WR_CYC (`MTS_VOL_WR_MS * `MTS_CLK_KHZ)
`define MTS_BPC_CYC (`MTS_BPC_MS * `MTS_CLK_KHZ)
`define MTS_HOLD_CYC (`MTS_HOLD_US * `MTS_CLK_KHZ / 1000)
`define MTS_STRETCH_CYC 5'd16

// ----------------------------------------
// bus framing
// ----------------------------------------
`define MTS_DEV_ADDR 7'h50
`define MTS_BITS_PER_BYTE 4'd8

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MTS_OFS_CHAR 8'h02
`define MTS_OFS_CTRL 8'h1a
`define MTS_OFS_PAGE 8'h7f
`define MTS_NV_BASE 8'h80

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define MTS_CHAR_MEM 7
`define MTS_CHAR_STEP 6
`define MTS_CHAR_SPD 2
`define MTS_CTRL_HWEN 6
`define MTS_CTRL_SQ 5
`define MTS_CTRL_SWLP 4
`define MTS_CTRL_SWRST 3
`define MTS_CTRL_RST 3'h0
`define MTS_PAGE_RST 8'h00

`endif

// ### include/mts_pkg.sv
package mts_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } mts_state_t;

  typedef struct packed {
    logic hw_lowpower_pin_enable;
    logic squelch_method_choice;
    logic sw_lowpower_request;
  } mts_ctrl_t;

endpackage

// ### rtl/mts_sync3.sv
`timescale 1ns/1ns
`default_nettype none

module mts_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // data
  input wire logic d_i,
  output logic q_o
);

  logic s1;
  logic s2;
  logic s3;

  // level accepted once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end

endmodule

`default_nettype wire

// ### testbench/mts_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module mts_host_model #(
  parameter int SETUP_CYC = 20,
  parameter int HOLD_CYC = 20
) (
  // clock
  input wire logic clk_i,
  // two-wire link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic module_select_n_o
);
  int timeouts = 0;

  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    module_select_n_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // release clock, wait out stretch, sample mid high phase
  task automatic scl_up(output logic s);
    int k;
    k = 0;
    scl_low_o = 1'b0;
    while (scl_i !== 1'b1 && k < 64) begin
      tick(1);
      k++;
    end
    if (k == 64) timeouts++;
    tick(5);
    s = sda_i;
    tick(5);
  endtask

  task automatic clk_bit(input logic b, output logic s);
    tick(5);
    sda_low_o = ~b;
    tick(5);
    scl_up(s);
    scl_low_o = 1'b1;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack);
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(nack, s);
  endtask

  task automatic start();
    sda_low_o = 1'b1;
    tick(10);
    scl_low_o = 1'b1;
  endtask

  task automatic rstart();
    logic s;
    tick(5);
    sda_low_o = 1'b0;
    tick(5);
    scl_up(s);
    start();
  endtask

  task automatic stop();
    logic s;
    tick(5);
    sda_low_o = 1'b1;
    tick(5);
    scl_up(s);
    sda_low_o = 1'b0;
    tick(10);
  endtask

  task automatic select();
    module_select_n_o = 1'b0;
    tick(SETUP_CYC);
  endtask

  task automatic deselect();
    tick(HOLD_CYC);
    module_select_n_o = 1'b1;
  endtask
endmodule

`default_nettype wire

// ### testbench/mts_twi_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mts_defs.svh"

module mts_twi_slave_bench;
  import mts_pkg::*;
  localparam int unsigned NV = 800;
  localparam int unsigned VOL = 400;
  localparam int unsigned BPC = 300;
  localparam logic [7:0] AW = {`MTS_DEV_ADDR, 1'b0};
  localparam logic [7:0] AR = {`MTS_DEV_ADDR, 1'b1};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hw_lp = 1'b0;
  logic scl_low, sda_low, sel_n, scl_w, sda_w;
  logic scl_oe, sda_oe, lowpower, sw_rst, busy;
  logic scl_v, sda_v;
  mts_ctrl_t ctrl;
  logic [7:0] page;
  int fail_count = 0;
  int n_tests = 0;
  int pulses = 0;

  always #4 clk = ~clk;
  // open-drain wires with pull-up
  assign scl_w = ~(scl_low | (scl_oe & ~scl_v));
  assign sda_w = ~(sda_low | (sda_oe & ~sda_v));
  always @(negedge clk) if (sw_rst === 1'b1) pulses++;

  mts_twi_slave #(.MEM_FLAT(1'b1), .MAX_SPEED(2'h2), .NV_WR_CYC(NV),
    .VOL_WR_CYC(VOL), .BPC_CYC(BPC)) uut (
    .clk_i(clk), .nrst_i(nrst), .scl_i(scl_w), .scl_o(scl_v),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_v), .sda_oe_o(sda_oe),
    .module_select_n_i(sel_n), .hw_lowpower_input_i(hw_lp), .ctrl_o(ctrl),
    .page_o(page), .lowpower_o(lowpower), .sw_module_reset_o(sw_rst),
    .busy_o(busy));

  mts_host_model host (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_low_o(scl_low), .sda_low_o(sda_low), .module_select_n_o(sel_n));

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_idle(input int unsigned lim);
    int unsigned n;
    n = 0;
    while (busy !== 1'b0) begin
      if (n > lim) begin
        chk(8'h01, 8'h00);
        close_out();
      end
      host.tick(1);
      n++;
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a0, a1, a2;
    host.select();
    host.start();
    host.send_byte(AW, a0);
    host.send_byte(p, a1);
    host.send_byte(d, a2);
    host.stop();
    host.deselect();
    chk({5'h0, a0, a1, a2}, 8'h00);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    logic a0, a1, a2;
    logic [7:0] d;
    host.select();
    host.start();
    host.send_byte(AW, a0);
    host.send_byte(p, a1);
    host.rstart();
    host.send_byte(AR, a2);
    host.recv_byte(1'b1, d);
    host.stop();
    host.deselect();
    chk({5'h0, a0, a1, a2}, 8'h00);
    chk(d, exp);
  endtask

  task automatic t_reset();
    chk({5'h0, ctrl}, 8'h00);
    chk(page, 8'h00);
    chk({3'h0, scl_oe, sda_oe, lowpower, sw_rst, busy}, 8'h00);
    chk({6'h0, scl_v, sda_v}, 8'h00);
    rd_chk(`MTS_OFS_CHAR, 8'h88);
    rd_chk(`MTS_OFS_CTRL, 8'h00);
  endtask

  task automatic t_readonly();
    wr(`MTS_OFS_CHAR, 8'h00);
    wait_idle(VOL);
    rd_chk(`MTS_OFS_CHAR, 8'h88);
  endtask

  task automatic t_ctrl();
    logic a;
    wr(`MTS_OFS_CTRL, 8'h30);
    chk({4'h0, ctrl, lowpower}, 8'h07);
    chk({7'h0, busy}, 8'h01);
    host.select();
    host.start();
    host.send_byte(AW, a);
    host.stop();
    host.deselect();
    chk({7'h0, a}, 8'h01);
    wait_idle(VOL);
    rd_chk(`MTS_OFS_CTRL, 8'h30);
  endtask

  task automatic t_hw();
    wr(`MTS_OFS_CTRL, 8'h40);
    wait_idle(VOL);
    chk({5'h0, ctrl}, 8'h04);
    hw_lp = 1'b1;
    host.tick(8);
    chk({7'h0, lowpower}, 8'h01);
    hw_lp = 1'b0;
    host.tick(8);
    chk({7'h0, lowpower}, 8'h00);
    wr(`MTS_OFS_CTRL, 8'h00);
    wait_idle(VOL);
    hw_lp = 1'b1;
    host.tick(8);
    chk({7'h0, lowpower}, 8'h00);
    hw_lp = 1'b0;
  endtask

  task automatic t_page();
    wr(`MTS_OFS_PAGE, 8'h05);
    chk(page, 8'h05);
    wait_idle(BPC);
    rd_chk(`MTS_OFS_PAGE, 8'h05);
  endtask

  task automatic t_nv();
    wr(`MTS_NV_BASE, 8'h5a);
    chk({7'h0, busy}, 8'h01);
    wait_idle(NV);
  endtask

  task automatic t_swrst();
    int p0;
    wr(`MTS_OFS_CTRL, 8'h70);
    wait_idle(VOL);
    p0 = pulses;
    wr(`MTS_OFS_CTRL, 8'h08);
    chk(8'(pulses - p0), 8'h01);
    chk({5'h0, ctrl}, 8'h00);
    chk(page, 8'h00);
    wait_idle(VOL);
  endtask

  // deselect while the module drives a data bit
  task automatic t_desel();
    logic a;
    host.select();
    host.start();
    host.send_byte(AW, a);
    host.send_byte(`MTS_OFS_CHAR, a);
    host.rstart();
    host.send_byte(AR, a);
    host.clk_bit(1'b1, a);
    host.tick(6);
    chk({7'h0, sda_oe}, 8'h01);
    host.deselect();
    host.tick(8);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    host.stop();
    host.start();
    host.send_byte(AW, a);
    host.stop();
    chk({7'h0, a}, 8'h01);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    host.tick(10);
    t_reset();
    t_readonly();
    t_ctrl();
    t_hw();
    t_page();
    t_nv();
    t_swrst();
    t_desel();
    rd_chk(`MTS_OFS_CHAR, 8'h88);
    chk(8'(host.timeouts), 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
